// [verilog/acsp_device.sv]
`timescale 1ns/100ps
module acsp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid & in_ready;
    assign out_valid = (count != '0);
    assign pop = out_ready & out_valid;
    assign out_data = mem[rd_ptr];
    assign next_count = count + CW'(push) - CW'(pop);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            count <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            count <= next_count;
            in_ready <= (next_count != CW'(DEPTH));
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule : acsp_fifo

module acsp_engine (
    input wire logic clock,
    input wire logic rst,
    input wire logic drive_clocks,
    input wire logic [1:0] fmt,
    input wire logic [1:0] wl,
    input wire logic fpol,
    input wire logic [7:0] divider,
    input wire logic bclk_pin,
    input wire logic frame_pin,
    input wire logic sdata_pin,
    output logic bclk_o,
    output logic frame_o,
    output logic clk_oe,
    output logic sdata_o,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [31:0] tx_data,
    output logic rx_valid,
    output logic [31:0] rx_data
);
    logic bclk_s1, bclk_s2, frm_s1, frm_s2, sd_s1, sd_s2, bclk_d;
    logic frm_last, phase_left, rise, fall, is_dsp, left_lvl;
    logic frame_edge, ph_now, left_start, next_sd, in_rx, f_valid;
    logic [6:0] cnt, half_len, hl_now, q, n, s_tx, s_rx, idx;
    logic [31:0] tx_word, word_now, rx_shift, f_data, next_shift;
    logic [7:0] div_cnt;
    logic [5:0] bc, next_bc;

    function automatic logic [6:0] slot_start(input logic [1:0] f, input logic p,
                                              input logic [6:0] hl, input logic [6:0] w);
        case (f)
            acsp_pkg::FMT_LJ: slot_start = 7'h00;
            acsp_pkg::FMT_I2S: slot_start = 7'h01;
            acsp_pkg::FMT_RJ: slot_start = (hl >= w) ? hl - w : 7'h00;
            default: slot_start = p ? 7'h00 : 7'h01;
        endcase
    endfunction : slot_start

    // Link lines pass two flops before use
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            {bclk_s1, bclk_s2, frm_s1, frm_s2, sd_s1, sd_s2, bclk_d} <= 7'h00;
        end
        else
        begin
            bclk_s1 <= bclk_pin;
            bclk_s2 <= bclk_s1;
            frm_s1 <= frame_pin;
            frm_s2 <= frm_s1;
            sd_s1 <= sdata_pin;
            sd_s2 <= sd_s1;
            bclk_d <= bclk_s2;
        end
    end

    assign rise = bclk_s2 & ~bclk_d;
    assign fall = ~bclk_s2 & bclk_d;
    assign is_dsp = (fmt == acsp_pkg::FMT_DSP);
    assign left_lvl = (fmt != acsp_pkg::FMT_I2S) ^ fpol;
    assign frame_edge = is_dsp ? (frm_s2 & ~frm_last) : (frm_s2 != frm_last);
    assign ph_now = frame_edge ? (is_dsp | (frm_s2 == left_lvl)) : phase_left;
    assign hl_now = frame_edge ? cnt : half_len;
    assign q = frame_edge ? 7'h00 : cnt;
    assign n = acsp_pkg::word_bits(fmt, wl);
    assign s_tx = slot_start(fmt, fpol, hl_now, n);
    assign s_rx = slot_start(fmt, fpol, half_len, n);
    assign left_start = fall & frame_edge & ph_now;
    assign word_now = left_start ? (f_valid ? f_data : 32'h00000000) : tx_word;

    // Next bit on the line, MSB first; DSP repeats the word in the right slot
    always_comb
    begin
        next_sd = 1'b0;
        idx = q - s_tx;
        if (q >= s_tx && q < s_tx + n)
            next_sd = word_now[~idx[4:0]];
        else if (is_dsp && q >= s_tx + n && q < s_tx + n + n)
        begin
            idx = q - s_tx - n;
            next_sd = word_now[~idx[4:0]];
        end
    end

    // Bit position counter, restarted by each frame edge
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cnt <= 7'h00;
            half_len <= 7'h00;
            frm_last <= 1'b0;
            phase_left <= 1'b0;
        end
        else if (fall)
        begin
            frm_last <= frm_s2;
            if (frame_edge)
            begin
                cnt <= 7'h00;
                half_len <= cnt;
                phase_left <= ph_now;
            end
        end
        else if (rise && cnt != 7'h7F)
            cnt <= cnt + 7'h01;
    end

    // Transmit side loads one word per frame and shifts on falling edges
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_word <= 32'h00000000;
            sdata_o <= 1'b0;
        end
        else if (fall)
        begin
            sdata_o <= next_sd;
            if (left_start)
                tx_word <= word_now;
        end
    end

    acsp_fifo #(.WIDTH(acsp_pkg::SAMPLE_W), .DEPTH(acsp_pkg::FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(f_valid),
        .out_ready(left_start),
        .out_data(f_data)
    );

    // Receive side samples the left slot on rising edges
    assign in_rx = phase_left && cnt >= s_rx && cnt < s_rx + n;
    assign next_shift = {rx_shift[30:0], sd_s2};

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rx_shift <= 32'h00000000;
            rx_data <= 32'h00000000;
            rx_valid <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (rise && in_rx)
            begin
                rx_shift <= next_shift;
                if (cnt == s_rx + n - 7'h01)
                begin
                    rx_valid <= 1'b1;
                    rx_data <= next_shift << (7'h20 - n);
                end
            end
        end
    end

    // Clock generator: divider ticks toggle the bit clock
    // Count starts one short so the first frame half is full length
    assign next_bc = bc + 6'h01;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            div_cnt <= 8'h00;
            bc <= 6'h3F;
            bclk_o <= 1'b0;
            frame_o <= 1'b0;
            clk_oe <= 1'b0;
        end
        else
        begin
            clk_oe <= drive_clocks;
            if (!drive_clocks)
            begin
                div_cnt <= 8'h00;
                bc <= 6'h3F;
                bclk_o <= 1'b0;
                frame_o <= 1'b0;
            end
            else if (div_cnt + 8'h01 >= divider)
            begin
                div_cnt <= 8'h00;
                bclk_o <= ~bclk_o;
                if (bclk_o)
                begin
                    bc <= next_bc;
                    frame_o <= is_dsp ? (next_bc == 6'h00) : ~next_bc[5];
                end
            end
            else
                div_cnt <= div_cnt + 8'h01;
        end
    end
endmodule : acsp_engine

module acsp_device (
    input wire logic clock,
    input wire logic rst,
    input wire logic master_select,
    input wire logic [1:0] format_select,
    input wire logic frame_polarity_select,
    input wire logic [1:0] word_length_select,
    input wire logic [7:0] bit_clock_divider,
    input wire logic cap_valid,
    output logic cap_ready,
    input wire logic [31:0] cap_data,
    output logic play_valid,
    output logic [31:0] play_data,
    acsp_if.dev link
);
    logic ms, fp, bclk_o, frame_o, clk_oe, sd_o;
    logic [1:0] fmt, wl;
    logic [7:0] div;

    // Settings held in flops with defined reset values
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ms <= acsp_pkg::MASTER_RESET;
            fmt <= acsp_pkg::FMT_RESET;
            wl <= acsp_pkg::WL_RESET;
            fp <= acsp_pkg::FRAME_POLARITY_SELECT_RESET;
            div <= acsp_pkg::DIV_RESET;
        end
        else
        begin
            ms <= master_select;
            fmt <= format_select;
            wl <= word_length_select;
            fp <= frame_polarity_select;
            div <= bit_clock_divider;
        end
    end

    acsp_engine u_eng (
        .clock(clock),
        .rst(rst),
        .drive_clocks(ms),
        .fmt(fmt),
        .wl(wl),
        .fpol(fp),
        .divider(div),
        .bclk_pin(link.bit_clk),
        .frame_pin(link.frame),
        .sdata_pin(link.playback_data_in),
        .bclk_o(bclk_o),
        .frame_o(frame_o),
        .clk_oe(clk_oe),
        .sdata_o(sd_o),
        .tx_valid(cap_valid),
        .tx_ready(cap_ready),
        .tx_data(cap_data),
        .rx_valid(play_valid),
        .rx_data(play_data)
    );

    assign link.dev_bclk = bclk_o;
    assign link.dev_bclk_oe = clk_oe;
    assign link.dev_frame = frame_o;
    assign link.dev_frame_oe = clk_oe;
    assign link.capture_data_out = sd_o;
endmodule : acsp_device

// [verilog/acsp_pkg.sv]
package acsp_pkg;
    localparam logic [1:0] FMT_RJ = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_20 = 2'h1;
    localparam logic [1:0] WL_24 = 2'h2;
    localparam logic [1:0] WL_32 = 2'h3;
    localparam logic [1:0] FMT_RESET = FMT_I2S;
    localparam logic [1:0] WL_RESET = WL_24;
    localparam logic MASTER_RESET = 1'b0;
    localparam logic FRAME_POLARITY_SELECT_RESET = 1'b0;
    localparam logic [7:0] DIV_RESET = 8'h08;
    localparam int SAMPLE_W = 32;
    localparam int FIFO_DEPTH = 4;
    localparam int FRAME_CNT_W = 6;

    function automatic logic [6:0] word_bits(input logic [1:0] fmt, input logic [1:0] wl);
        logic [6:0] n;
        case (wl)
            WL_16: n = 7'h10;
            WL_20: n = 7'h14;
            WL_24: n = 7'h18;
            default: n = (fmt == FMT_RJ) ? 7'h18 : 7'h20;
        endcase
        return n;
    endfunction : word_bits
endpackage : acsp_pkg

// [verilog/acsp_if.sv]
`timescale 1ns/100ps
interface acsp_if;
    logic dev_bclk;
    logic dev_bclk_oe;
    logic dev_frame;
    logic dev_frame_oe;
    logic host_bclk;
    logic host_bclk_oe;
    logic host_frame;
    logic host_frame_oe;
    logic capture_data_out;
    logic playback_data_in;
    logic bit_clk;
    logic frame;

    // Shared clock lines resolved from whichever end drives them
    assign bit_clk = dev_bclk_oe ? dev_bclk : (host_bclk_oe & host_bclk);
    assign frame = dev_frame_oe ? dev_frame : (host_frame_oe & host_frame);

    modport dev (
        output dev_bclk, dev_bclk_oe, dev_frame, dev_frame_oe, capture_data_out,
        input bit_clk, frame, playback_data_in
    );
    modport host (
        output host_bclk, host_bclk_oe, host_frame, host_frame_oe, playback_data_in,
        input bit_clk, frame, capture_data_out
    );
endinterface : acsp_if

// [verilog/acsp_host.sv]
`timescale 1ns/100ps
module acsp_host (
    input wire logic clock,
    input wire logic rst,
    input wire logic master_select,
    input wire logic [1:0] format_select,
    input wire logic frame_polarity_select,
    input wire logic [1:0] word_length_select,
    input wire logic [7:0] bit_clock_divider,
    input wire logic play_valid,
    output logic play_ready,
    input wire logic [31:0] play_data,
    output logic cap_valid,
    output logic [31:0] cap_data,
    acsp_if.host link
);
    logic drive, fp, bclk_o, frame_o, clk_oe, sd_o;
    logic [1:0] fmt, wl;
    logic [7:0] div;

    // Host drives the clocks whenever the device is slave
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            drive <= ~acsp_pkg::MASTER_RESET;
            fmt <= acsp_pkg::FMT_RESET;
            wl <= acsp_pkg::WL_RESET;
            fp <= acsp_pkg::FRAME_POLARITY_SELECT_RESET;
            div <= acsp_pkg::DIV_RESET;
        end
        else
        begin
            drive <= ~master_select;
            fmt <= format_select;
            wl <= word_length_select;
            fp <= frame_polarity_select;
            div <= bit_clock_divider;
        end
    end

    acsp_engine u_eng (
        .clock(clock),
        .rst(rst),
        .drive_clocks(drive),
        .fmt(fmt),
        .wl(wl),
        .fpol(fp),
        .divider(div),
        .bclk_pin(link.bit_clk),
        .frame_pin(link.frame),
        .sdata_pin(link.capture_data_out),
        .bclk_o(bclk_o),
        .frame_o(frame_o),
        .clk_oe(clk_oe),
        .sdata_o(sd_o),
        .tx_valid(play_valid),
        .tx_ready(play_ready),
        .tx_data(play_data),
        .rx_valid(cap_valid),
        .rx_data(cap_data)
    );

    assign link.host_bclk = bclk_o;
    assign link.host_bclk_oe = clk_oe;
    assign link.host_frame = frame_o;
    assign link.host_frame_oe = clk_oe;
    assign link.playback_data_in = sd_o;
endmodule : acsp_host

// [testbench/acsp_chk.sv]
`timescale 1ns/100ps
module acsp_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic master_select,
    input wire logic [1:0] format_select,
    input wire logic [7:0] bit_clock_divider,
    input wire logic dev_bclk_oe,
    input wire logic dev_frame_oe,
    input wire logic host_bclk_oe,
    input wire logic capture_data_out,
    input wire logic playback_data_in,
    input wire logic bit_clk,
    input wire logic frame
);
    logic [1:0] up;
    logic [7:0] hcnt;
    logic [7:0] rcnt;
    logic seen_b;
    logic seen_f;
    logic dsp;
    assign dsp = format_select == 2'h3;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // Cycles since reset release, saturating
    always_ff @(posedge clock)
    begin
        if (rst)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end
    // Cycles since the last bit clock edge
    always_ff @(posedge clock)
    begin
        if (rst || $changed(bit_clk))
            hcnt <= 8'h00;
        else
            hcnt <= hcnt + 8'h01;
    end
    // Bit clock rises since the last frame edge
    always_ff @(posedge clock)
    begin
        if (rst || (dsp ? $rose(frame) : $changed(frame)))
            rcnt <= 8'h00;
        else if ($rose(bit_clk))
            rcnt <= rcnt + 8'h01;
    end
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            seen_b <= 1'b0;
            seen_f <= 1'b0;
        end
        else
        begin
            seen_b <= seen_b | $changed(bit_clk);
            seen_f <= seen_f | $changed(frame);
        end
    end
    a_master_clocks: assert property (
        up == 2'h3 && master_select |-> dev_bclk_oe && dev_frame_oe && !host_bclk_oe)
        else $error("master end not driving link clocks");
    a_slave_clocks: assert property (
        up == 2'h3 && !master_select |-> host_bclk_oe && !dev_bclk_oe && !dev_frame_oe)
        else $error("slave end drives link clocks");
    a_capture_stable: assert property (
        $rose(bit_clk) |-> $stable(capture_data_out) [*3])
        else $error("capture data moved while bit clock high");
    a_playback_stable: assert property (
        $rose(bit_clk) |-> $stable(playback_data_in) [*3])
        else $error("playback data moved while bit clock high");
    a_bclk_half_period: assert property (
        seen_b && $changed(bit_clk) |-> hcnt == bit_clock_divider - 8'h01)
        else $error("bit clock half period wrong");
    a_frame_on_fall: assert property (
        seen_f && $changed(frame) |-> $fell(bit_clk))
        else $error("frame moved off a bit clock fall");
    a_half_frame_len: assert property (
        seen_f && !dsp && $changed(frame) |-> rcnt == 8'h20)
        else $error("frame half length wrong");
    a_dsp_frame_len: assert property (
        seen_f && dsp && $rose(frame) |-> rcnt == 8'h40)
        else $error("pcm frame length wrong");
    a_dsp_pulse: assert property (
        seen_f && dsp && $fell(frame) |-> rcnt == 8'h01)
        else $error("pcm frame pulse width wrong");
    c_master_dsp: cover property (master_select && dsp && $rose(frame));
    c_slave_rj: cover property (!master_select && format_select == 2'h0 && $changed(frame));
    c_capture_one: cover property ($rose(bit_clk) && capture_data_out);
endmodule : acsp_chk

// [testbench/codec_audio_serial_port_test.sv]
`timescale 1ns/100ps
module codec_audio_serial_port_test;
    logic clock;
    logic rst;
    logic ms;
    logic [1:0] fmt;
    logic fp;
    logic [1:0] wl;
    logic [7:0] div;
    logic c_valid;
    logic c_ready;
    logic [31:0] c_data;
    logic p_valid;
    logic p_ready;
    logic [31:0] p_data;
    logic rx_p_valid;
    logic [31:0] rx_p_data;
    logic rx_c_valid;
    logic [31:0] rx_c_data;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int rises = 0;
    logic pb = 1'b0;
    logic pf = 1'b0;
    logic saw_full;
    logic [63:0] sh = 64'h0;
    logic [63:0] q_c[$];
    logic [63:0] q_p[$];
    logic [63:0] q_w[$];
    logic [31:0] wd[6];
    acsp_if link();
    acsp_device acsp_device_inst (.clock(clock), .rst(rst), .master_select(ms),
        .format_select(fmt), .frame_polarity_select(fp), .word_length_select(wl),
        .bit_clock_divider(div), .cap_valid(c_valid), .cap_ready(c_ready), .cap_data(c_data),
        .play_valid(rx_p_valid), .play_data(rx_p_data), .link(link));
    acsp_host acsp_host_inst (.clock(clock), .rst(rst), .master_select(ms),
        .format_select(fmt), .frame_polarity_select(fp), .word_length_select(wl),
        .bit_clock_divider(div), .play_valid(p_valid), .play_ready(p_ready), .play_data(p_data),
        .cap_valid(rx_c_valid), .cap_data(rx_c_data), .link(link));
    acsp_chk acsp_chk_inst (.clock(clock), .rst(rst), .master_select(ms), .format_select(fmt),
        .bit_clock_divider(div), .dev_bclk_oe(link.dev_bclk_oe),
        .dev_frame_oe(link.dev_frame_oe), .host_bclk_oe(link.host_bclk_oe),
        .capture_data_out(link.capture_data_out), .playback_data_in(link.playback_data_in),
        .bit_clk(link.bit_clk), .frame(link.frame));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Word k after the leading idle zeros
    function automatic logic [63:0] nth(input logic [63:0] q[$], input int k);
        int z;
        z = 0;
        while (z < q.size() && q[z] == 64'h0)
            z++;
        return (z + k < q.size()) ? q[z + k] : 64'hX;
    endfunction : nth
    task automatic push(input logic host_side, input logic [31:0] d);
        int n;
        n = 0;
        if (host_side)
        begin
            p_valid <= 1'b1;
            p_data <= d;
        end
        else
        begin
            c_valid <= 1'b1;
            c_data <= d;
        end
        do
        begin
            @(posedge clock);
            n++;
            if (!(host_side ? p_ready : c_ready))
                saw_full = 1'b1;
        end
        while (!(host_side ? p_ready : c_ready) && n < 3000);
    endtask : push
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fails++;
            final_report();
        end
    end
    // Received words, one per frame, and the raw capture line, one entry per half frame or pcm frame
    always @(posedge clock)
    begin
        if (rx_c_valid)
            q_c.push_back({32'h0, rx_c_data});
        if (rx_p_valid)
            q_p.push_back({32'h0, rx_p_data});
        if (link.bit_clk && !pb)
        begin
            sh = {sh[62:0], link.capture_data_out};
            rises++;
        end
        if (link.frame !== pf && (fmt != 2'h3 || link.frame))
        begin
            if (rises == (fmt == 2'h3 ? 64 : 32))
                q_w.push_back(fmt == 2'h3 ? sh : {32'h0, sh[31:0]});
            rises = 0;
        end
        pb = link.bit_clk;
        pf = link.frame;
    end
    initial
    begin
        int n;
        int s;
        logic [31:0] mask;
        logic [63:0] e;
        logic [63:0] t;
        logic [63:0] w;
        rst <= 1'b1;
        ms <= 1'b0;
        fmt <= 2'h2;
        fp <= 1'b0;
        wl <= 2'h2;
        div <= 8'h05;
        c_valid <= 1'b0;
        c_data <= 32'h0;
        p_valid <= 1'b0;
        p_data <= 32'h0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            rst <= 1'b1;
            ms <= i[0] ^ i[2];
            fmt <= i[1:0];
            fp <= ~i[2];
            wl <= i[1:0] - {1'b0, i[2]};
            div <= 8'h05 + 8'(i[0]);
            repeat (2) @(posedge clock);
            rst <= 1'b0;
            repeat (256 * 6) @(posedge clock);
            n = wl == 2'h3 ? (fmt == 2'h0 ? 24 : 32) : 16 + 4 * int'(wl);
            s = fmt == 2'h1 ? 0 : fmt == 2'h2 ? 1 : fmt == 2'h0 ? 32 - n : int'(!fp);
            mask = 32'hFFFF_FFFF << (32 - n);
            q_c.delete();
            q_p.delete();
            q_w.delete();
            saw_full = 1'b0;
            for (int k = 0; k < 12; k++)
            begin
                wd[k % 6] = {4'h9, 4'(i), 4'(k % 6), 20'h5A5C3};
                push(k >= 6, wd[k % 6] ^ (k >= 6 ? 32'h7F00_0000 : 32'h0));
                if (k == 5)
                    c_valid <= 1'b0;
            end
            p_valid <= 1'b0;
            repeat (768 * 6) @(posedge clock);
            check({63'h0, saw_full}, 64'h1);
            for (int k = 0; k < 6; k++)
            begin
                e = {wd[k] & mask, 32'h0};
                t = e >> s;
                w = fmt == 2'h3 ? t | (e >> (s + n)) : {32'h0, t[63:32]};
                check(nth(q_c, k), {32'h0, e[63:32]});
                check(nth(q_p, k), {32'h0, e[63:32] ^ (32'h7F00_0000 & mask)});
                check(nth(q_w, fmt == 2'h3 ? k : 2 * k), w);
                if (fmt != 2'h3)
                    check(nth(q_w, 2 * k + 1), w);
            end
        end
        final_report();
    end
endmodule : codec_audio_serial_port_test
